// ===== hdl/stc_params.svh
// Offsets, field positions, reset values and timing counts of the 16-bit timer/counter.
// Assumes the block clock is the high-frequency system clock fc.
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------
`define STC_ADDR_CTRL 8'h00
`define STC_ADDR_PERIOD 8'h04
`define STC_ADDR_CAPTURE 8'h08
`define STC_ADDR_EXTINT 8'h0c
`define STC_ADDR_SYSCTL 8'h10
`define STC_ADDR_STATUS 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STC_CTRL_MODE_TOP 7
`define STC_CTRL_SCAP 6
`define STC_CTRL_START_HI 5
`define STC_CTRL_START_LO 4
`define STC_CTRL_CLK_HI 3
`define STC_CTRL_CLK_LO 2
`define STC_CTRL_MODE_HI 1
`define STC_CTRL_MODE_LO 0
`define STC_EXT_EDGE_BIT 2
`define STC_SYS_DV7_BIT 0
`define STC_SYS_SLOW_BIT 1
`define STC_STAT_RUN_BIT 16
`define STC_STAT_WAIT_BIT 17

// ----------------------------------------------------------------
// Reset values and start field codes
// ----------------------------------------------------------------
`define STC_MODE_RESET 3'h0
`define STC_CLK_RESET 2'h0
`define STC_START_RESET 2'h0
`define STC_START_STOP 2'h0
`define STC_START_CMD 2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STC_CLOCK_MHZ 25
`define STC_FC_DIV_W 11
`define STC_FC_DIV_HI 11
`define STC_FC_DIV_MID 7
`define STC_FC_DIV_LO 3
`define STC_FS_DIV 3
`define STC_REJECT_FC 7
`define STC_ACCEPT_FC 24
`define STC_FILT_CYCLES ((`STC_REJECT_FC + `STC_ACCEPT_FC + 1) / 2)
`define STC_FILT_W 5

`endif

// ===== hdl/stc_pkg.sv
// Types shared by the 16-bit timer/counter files.
// Assumes nothing of its surroundings.
package stc_pkg;

	// ----------------------------------------------------------------
	// Counter states and operating modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		STC_ST_STOP = 3'b001,
		STC_ST_WAIT = 3'b010,
		STC_ST_RUN = 3'b100
	} stc_state_t;

	typedef enum logic [2:0] {
		STC_MODE_TIMER = 3'h0,
		STC_MODE_EXTTRIG = 3'h1,
		STC_MODE_EVENT = 3'h2,
		STC_MODE_WINDOW = 3'h3,
		STC_MODE_PULSEW = 3'h4,
		STC_MODE_PULSEGEN = 3'h5
	} stc_mode_t;

endpackage

// ===== hdl/stc_filter.sv
// Noise filter and edge detector for the counter input pin.
// Assumes the pin is synchronous to clock and clock is fc.
`timescale 1ns/100ps
`include "stc_params.svh"

module stc_filter (
	input wire logic clock,
	input wire logic nrst,
	input wire logic pin,
	input wire logic bypass,
	output logic level,
	output logic rise,
	output logic fall
);

	logic [`STC_FILT_W-1:0] cnt_reg;
	logic [`STC_FILT_W-1:0] cnt_next;
	logic level_reg;
	logic level_next;
	logic rise_reg;
	logic rise_next;
	logic fall_reg;
	logic fall_next;
	logic accept;

	// Unless bypass is set, a new level is taken only once the pin has differed for the whole filter
	// time; shorter pulses restart the count and are lost.
	always_comb begin
		cnt_next = '0;
		level_next = level_reg;
		rise_next = 1'b0;
		fall_next = 1'b0;
		accept = bypass || (cnt_reg == `STC_FILT_W'(`STC_FILT_CYCLES - 1));
		if (pin != level_reg) begin
			if (accept) begin
				level_next = pin;
				rise_next = pin;
				fall_next = !pin;
			end else begin
				cnt_next = cnt_reg + `STC_FILT_W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			cnt_reg <= '0;
			level_reg <= 1'b0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			level_reg <= level_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
		end
	end

	assign level = level_reg;
	assign rise = rise_reg;
	assign fall = fall_reg;

endmodule

// ===== hdl/stc_timer.sv
// 16-bit timer/counter with period compare, software capture and a pin input.
// Assumes an AHB-Lite master on the bus, clock as fc and fs_tick as one pulse per fs period.
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`include "stc_params.svh"

module stc_timer
	import stc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic fs_tick,
	input wire logic counter_input_pin,
	output logic match_interrupt
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic addr_phase;
	logic wr_pend_reg;
	logic wr_pend_next;
	logic [7:0] wr_addr_reg;
	logic [7:0] wr_addr_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic wr_ctrl;
	logic [2:0] wr_mode;

	stc_mode_t mode_reg;
	stc_mode_t mode_next;
	logic [1:0] clk_sel_reg;
	logic [1:0] clk_sel_next;
	logic [1:0] start_reg;
	logic [1:0] start_next;
	logic edge_stop_reg;
	logic edge_stop_next;
	logic edge_sel_reg;
	logic edge_sel_next;
	logic dv7_reg;
	logic dv7_next;
	logic slow_reg;
	logic slow_next;

	logic [`STC_FC_DIV_W-1:0] fc_div_reg;
	logic [`STC_FC_DIV_W-1:0] fc_div_next;
	logic [`STC_FS_DIV-1:0] fs_div_reg;
	logic [`STC_FS_DIV-1:0] fs_div_next;
	logic fs_t3;
	logic tick_int;

	logic filt_level;
	logic filt_rise;
	logic filt_fall;
	logic trig_edge;
	logic opp_edge;
	logic gate_on;

	stc_state_t state_reg;
	stc_state_t state_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [15:0] period_reg;
	logic [15:0] period_next;
	logic [15:0] capture_reg;
	logic [15:0] capture_next;
	logic match_reg;
	logic match_next;
	logic count_en;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// Zero wait states: read data are picked in the address phase and held in a
	// flip-flop for the data phase; writes are applied from the data phase.
	assign addr_phase = hsel && hready && htrans[1];

	always_comb begin
		wr_pend_next = addr_phase && hwrite;
		wr_addr_next = addr_phase ? haddr[7:0] : wr_addr_reg;
		rdata_next = 32'h0;
		if (addr_phase && !hwrite) begin
			unique case (haddr[7:0])
				`STC_ADDR_PERIOD: rdata_next = {16'h0, period_reg};
				`STC_ADDR_CAPTURE: rdata_next = {16'h0, capture_reg};
				`STC_ADDR_EXTINT: rdata_next[`STC_EXT_EDGE_BIT] = edge_sel_reg;
				`STC_ADDR_SYSCTL: begin
					rdata_next[`STC_SYS_DV7_BIT] = dv7_reg;
					rdata_next[`STC_SYS_SLOW_BIT] = slow_reg;
				end
				`STC_ADDR_STATUS: begin
					rdata_next[15:0] = cnt_reg;
					rdata_next[`STC_STAT_RUN_BIT] = (state_reg == STC_ST_RUN);
					rdata_next[`STC_STAT_WAIT_BIT] = (state_reg == STC_ST_WAIT);
				end
				default: rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rdata_reg <= 32'h0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			rdata_reg <= rdata_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;
	assign wr_ctrl = wr_pend_reg && (wr_addr_reg == `STC_ADDR_CTRL);
	assign wr_mode = {hwdata[`STC_CTRL_MODE_TOP], hwdata[`STC_CTRL_MODE_HI:`STC_CTRL_MODE_LO]};

	// ----------------------------------------------------------------
	// Control and configuration registers
	// ----------------------------------------------------------------
	// The control word is replaced whole on every write; the capture bit is a
	// command in counting modes and the edge-stop option in trigger mode.
	always_comb begin
		mode_next = mode_reg;
		clk_sel_next = clk_sel_reg;
		start_next = start_reg;
		edge_stop_next = edge_stop_reg;
		edge_sel_next = edge_sel_reg;
		dv7_next = dv7_reg;
		slow_next = slow_reg;
		if (wr_ctrl) begin
			mode_next = stc_mode_t'(wr_mode);
			clk_sel_next = hwdata[`STC_CTRL_CLK_HI:`STC_CTRL_CLK_LO];
			start_next = hwdata[`STC_CTRL_START_HI:`STC_CTRL_START_LO];
			edge_stop_next = hwdata[`STC_CTRL_SCAP];
		end
		if (wr_pend_reg && (wr_addr_reg == `STC_ADDR_EXTINT)) begin
			edge_sel_next = hwdata[`STC_EXT_EDGE_BIT];
		end
		if (wr_pend_reg && (wr_addr_reg == `STC_ADDR_SYSCTL)) begin
			dv7_next = hwdata[`STC_SYS_DV7_BIT];
			slow_next = hwdata[`STC_SYS_SLOW_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			mode_reg <= stc_mode_t'(`STC_MODE_RESET);
			clk_sel_reg <= `STC_CLK_RESET;
			start_reg <= `STC_START_RESET;
			edge_stop_reg <= 1'b0;
			edge_sel_reg <= 1'b0;
			dv7_reg <= 1'b0;
			slow_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			clk_sel_reg <= clk_sel_next;
			start_reg <= start_next;
			edge_stop_reg <= edge_stop_next;
			edge_sel_reg <= edge_sel_next;
			dv7_reg <= dv7_next;
			slow_reg <= slow_next;
		end
	end

	// ----------------------------------------------------------------
	// Source clock dividers
	// ----------------------------------------------------------------
	always_comb begin
		fc_div_next = fc_div_reg + `STC_FC_DIV_W'(1);
		fs_div_next = fs_tick ? fs_div_reg + `STC_FS_DIV'(1) : fs_div_reg;
		fs_t3 = fs_tick && (&fs_div_reg);
		if (slow_reg) begin
			tick_int = fs_t3;
		end else begin
			unique case (clk_sel_reg)
				2'h0: tick_int = dv7_reg ? fs_t3 : (&fc_div_reg[`STC_FC_DIV_HI-1:0]);
				2'h1: tick_int = &fc_div_reg[`STC_FC_DIV_MID-1:0];
				default: tick_int = &fc_div_reg[`STC_FC_DIV_LO-1:0];
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			fc_div_reg <= '0;
			fs_div_reg <= '0;
		end else begin
			fc_div_reg <= fc_div_next;
			fs_div_reg <= fs_div_next;
		end
	end

	// ----------------------------------------------------------------
	// Pin input
	// ----------------------------------------------------------------
	stc_filter u_filter (
		.clock(clock),
		.nrst(nrst),
		.pin(counter_input_pin),
		.bypass(slow_reg),
		.level(filt_level),
		.rise(filt_rise),
		.fall(filt_fall)
	);

	assign trig_edge = edge_sel_reg ? filt_fall : filt_rise;
	assign opp_edge = edge_sel_reg ? filt_rise : filt_fall;
	assign gate_on = filt_level ^ edge_sel_reg;

	// ----------------------------------------------------------------
	// Counter, compare and capture
	// ----------------------------------------------------------------
	always_comb begin
		unique case (mode_reg)
			STC_MODE_TIMER: count_en = tick_int;
			STC_MODE_EXTTRIG: count_en = tick_int;
			STC_MODE_EVENT: count_en = trig_edge;
			STC_MODE_WINDOW: count_en = tick_int && gate_on;
			default: count_en = 1'b0;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		match_next = 1'b0;
		period_next = period_reg;
		capture_next = capture_reg;
		unique case (state_reg)
			STC_ST_STOP: state_next = STC_ST_STOP;
			STC_ST_WAIT: begin
				if (trig_edge) begin
					state_next = STC_ST_RUN;
				end
			end
			STC_ST_RUN: begin
				if (count_en) begin
					if (cnt_reg == period_reg) begin
						cnt_next = 16'h0;
						match_next = 1'b1;
						if (mode_reg == STC_MODE_EXTTRIG) begin
							state_next = STC_ST_WAIT;
						end
					end else begin
						cnt_next = cnt_reg + 16'h1;
					end
				end
				// In trigger mode, trigger edges during a run fall through here unused; event mode counts them above.
				if ((mode_reg == STC_MODE_EXTTRIG) && edge_stop_reg && opp_edge) begin
					cnt_next = 16'h0;
					state_next = STC_ST_WAIT;
				end
			end
		endcase
		if (wr_ctrl) begin
			if (hwdata[`STC_CTRL_START_HI:`STC_CTRL_START_LO] == `STC_START_STOP) begin
				state_next = STC_ST_STOP;
				cnt_next = 16'h0;
			end else if (state_reg == STC_ST_STOP) begin
				cnt_next = 16'h0;
				if (hwdata[`STC_CTRL_START_HI] || (wr_mode == STC_MODE_EXTTRIG)) begin
					state_next = STC_ST_WAIT;
				end else begin
					state_next = STC_ST_RUN;
				end
			end
			if (hwdata[`STC_CTRL_SCAP] && ((wr_mode == STC_MODE_TIMER)
					|| (wr_mode == STC_MODE_EVENT) || (wr_mode == STC_MODE_WINDOW))) begin
				capture_next = cnt_reg;
			end
		end
		if (wr_pend_reg && (wr_addr_reg == `STC_ADDR_PERIOD)) begin
			period_next = hwdata[15:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg <= STC_ST_STOP;
			cnt_reg <= 16'h0;
			match_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			match_reg <= match_next;
		end
	end

	// Period and capture keep their contents through reset.
	always_ff @(posedge clock) begin
		period_reg <= period_next;
		capture_reg <= capture_next;
	end

	assign match_interrupt = match_reg;

endmodule

// ===== dv/stc_timer_props.sv
// Checker for the ports of the timer/counter.
// Assumes hready is tied to hreadyout.
`timescale 1ns/100ps
module stc_timer_props (
	input wire logic clock,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic fs_tick,
	input wire logic counter_input_pin,
	input wire logic match_interrupt
);
	// ----
	// Read data phase tracking
	// ----
	logic rd_reg;
	logic [7:0] ra_reg;
	always_ff @(posedge clock) begin
		rd_reg <= nrst && hsel && hready && htrans[1] && !hwrite;
		ra_reg <= haddr[7:0];
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_PULSE: assert property (match_interrupt |=> !match_interrupt)
		else $error("match pulse longer than one cycle");
	AST_GAP: assert property (match_interrupt |=> !match_interrupt [*7])
		else $error("matches closer than the fastest tick");
	AST_RST: assert property ($rose(nrst) |-> !match_interrupt)
		else $error("match pulse out of reset");
	AST_CTRL_RD: assert property (rd_reg && ra_reg == 8'h00 |-> hrdata == 32'h0)
		else $error("control register readable");
	AST_REG_W: assert property (rd_reg && ra_reg inside {8'h04, 8'h08} |-> hrdata[31:16] == 16'h0)
		else $error("timer register wider than 16 bits");
	AST_STAT_W: assert property (rd_reg && ra_reg == 8'h14 |-> hrdata[31:18] == 14'h0)
		else $error("status upper bits set");
	AST_IDLE: assert property (!rd_reg |-> hrdata == 32'h0)
		else $error("read data outside a read");
	AST_OKAY: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
endmodule

// ===== dv/stc_pulse_src.sv
// Model of the pulse source on the counter input pin.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/100ps
module stc_pulse_src (
	input wire logic clock,
	output logic pin
);
	initial pin = 1'b0;
	// Holds a level for n clocks; callers keep it at 16 or more except for a wanted glitch.
	task automatic hold(input logic lv, input int n);
		pin <= lv;
		repeat (n) @(posedge clock);
	endtask
endmodule

// ===== dv/stc_timer_tb.sv
// Self-checking bench of the timer/counter over AHB-Lite.
// Assumes stc_timer, stc_pulse_src and stc_timer_props are compiled first.
`timescale 1ns/100ps
module stc_timer_tb;
	logic clock, nrst, hsel, hwrite, hready, hreadyout, hresp, fs_tick, pin, match_interrupt;
	logic [31:0] haddr, hwdata, hrdata, q, c, s;
	logic [1:0] htrans, fs_cnt;
	logic [2:0] hsize;
	int n_errors = 0, checks = 0, n_match = 0, cyc = 0, n, m;
	logic [1:0] sys_t [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
	logic [1:0] clk_t [5] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h2};
	logic [15:0] per_t [5] = '{16'h3, 16'h1, 16'h0, 16'h1, 16'h1};
	int exp_t [5] = '{32, 256, 2048, 64, 64};
	assign hready = hreadyout;
	stc_timer DUT (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fs_tick(fs_tick),
		.counter_input_pin(pin), .match_interrupt(match_interrupt));
	stc_pulse_src u_src (.clock(clock), .pin(pin));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		fs_cnt <= nrst ? fs_cnt + 2'h1 : 2'h0;
		fs_tick <= nrst && fs_cnt == 2'h3;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end
	always @(negedge clock) if (match_interrupt === 1'b1) n_match++;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		xfer(1'b0, a, 32'h0, r);
	endtask
	// Cycles from one match pulse to the next.
	task automatic gap(output int g);
		g = 1;
		@(negedge clock);
		while (match_interrupt !== 1'b1) @(negedge clock);
		@(negedge clock);
		while (match_interrupt !== 1'b1) begin
			g++;
			@(negedge clock);
		end
		@(posedge clock);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		rd(8'h00, q); chk(q, 32'h0);
		wr(8'h04, 32'hffff1234);
		rd(8'h04, q); chk(q, 32'h1234);
		rd(8'h20, q); chk(q, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			wr(8'h10, {30'h0, sys_t[i]});
			wr(8'h04, {16'h0, per_t[i]});
			wr(8'h00, 32'h0);
			wr(8'h00, {26'h1, clk_t[i], 2'h0});
			gap(n);
			chk(32'(n), 32'(exp_t[i]));
		end
		wr(8'h10, 32'h0);
		wr(8'h04, 32'hffff);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h18);
		repeat (100) @(posedge clock);
		rd(8'h14, s);
		wr(8'h00, 32'h58);
		rd(8'h08, c);
		chk(32'(c[15:0] - s[15:0] <= 16'h1), 32'h1);
		repeat (40) @(posedge clock);
		rd(8'h08, q); chk(q, c);
		rd(8'h14, q); chk(32'(q[16] && q[15:0] > c[15:0]), 32'h1);
		nrst <= 1'b0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		rd(8'h04, q); chk(q, 32'hffff);
		rd(8'h08, q); chk(q, c);
		$display("test timer done");
		wr(8'h0c, 32'h0);
		wr(8'h04, 32'h3);
		wr(8'h00, 32'h29);
		rd(8'h14, q); chk(q, 32'h20000);
		m = n_match;
		u_src.hold(1'b1, 200);
		chk(32'(n_match - m), 32'h1);
		rd(8'h14, q); chk(q, 32'h20000);
		u_src.hold(1'b0, 40);
		rd(8'h14, q); chk(q, 32'h20000);
		u_src.hold(1'b1, 200);
		chk(32'(n_match - m), 32'h2);
		wr(8'h04, 32'h20);
		u_src.hold(1'b0, 40);
		u_src.hold(1'b1, 60);
		u_src.hold(1'b0, 30);
		u_src.hold(1'b1, 60);
		rd(8'h14, q); chk(32'(q[16] && q[15:0] >= 16'hc), 32'h1);
		wr(8'h00, 32'h69);
		u_src.hold(1'b0, 40);
		rd(8'h14, q); chk(q, 32'h20000);
		$display("test trigger done");
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h12);
		m = n_match;
		u_src.hold(1'b1, 7);
		u_src.hold(1'b0, 30);
		rd(8'h14, q); chk(q[15:0], 16'h0);
		repeat (3) begin
			u_src.hold(1'b1, 30);
			u_src.hold(1'b0, 30);
		end
		chk(32'(n_match - m), 32'h1);
		rd(8'h14, q); chk(q[15:0], 16'h0);
		wr(8'h0c, 32'h4);
		u_src.hold(1'b1, 30);
		u_src.hold(1'b0, 30);
		rd(8'h14, q); chk(q[15:0], 16'h1);
		// A pulse too short for the filter still counts once the filter is bypassed.
		wr(8'h10, 32'h2);
		u_src.hold(1'b1, 8);
		u_src.hold(1'b0, 60);
		rd(8'h14, q); chk(q[15:0], 16'h2);
		wr(8'h10, 32'h0);
		$display("test event done");
		wr(8'h00, 32'h0);
		wr(8'h0c, 32'h0);
		wr(8'h04, 32'hffff);
		wr(8'h00, 32'h1b);
		repeat (100) @(posedge clock);
		rd(8'h14, q); chk(q[15:0], 16'h0);
		u_src.hold(1'b1, 160);
		u_src.hold(1'b0, 40);
		rd(8'h14, q); chk(32'(q[15:0] >= 16'h12 && q[15:0] <= 16'h16), 32'h1);
		wr(8'h0c, 32'h4);
		rd(8'h14, s);
		repeat (80) @(posedge clock);
		rd(8'h14, q); chk(32'(q[15:0] - s[15:0] >= 16'h8), 32'h1);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h98);
		repeat (40) @(posedge clock);
		rd(8'h14, q); chk(q, 32'h10000);
		$display("test window done");
		results();
	end
endmodule
bind stc_timer stc_timer_props u_props (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fs_tick(fs_tick),
	.counter_input_pin(counter_input_pin), .match_interrupt(match_interrupt));
